// [logic/rf_tx_gear_pkg.sv]
package rf_tx_gear_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_GUARD    = 8'h04;
  localparam logic [7:0] ADDR_LEVEL    = 8'h08;
  localparam logic [7:0] ADDR_CLK      = 8'h0c;
  localparam logic [7:0] ADDR_GEAR     = 8'h10;
  localparam logic [7:0] ADDR_PROTO    = 8'h14;
  localparam logic [7:0] ADDR_LUT_IDX  = 8'h18;
  localparam logic [7:0] ADDR_LUT_DATA = 8'h1c;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  // Control register bits
  localparam int CTRL_LAUNCH      = 0;
  localparam int CTRL_GRID_SYNC   = 1;
  localparam int CTRL_FIELD_GUARD = 2;
  localparam int CTRL_MULTI_RX    = 3;
  localparam int CTRL_FIELD_ON    = 4;
  // Level register fields
  localparam int LVL_RES_LSB      = 0;
  localparam int LVL_RES_SHP_LSB  = 8;
  localparam int LVL_FALL_LSB     = 16;
  localparam int LVL_RISE_LSB     = 20;
  // Clock register fields
  localparam int CLK_MODE_LSB     = 0;
  localparam int CLK_SHP_LSB      = 4;
  // Gear register fields
  localparam int GEAR_IVL_LSB     = 0;
  localparam int GEAR_MAX_LSB     = 8;
  localparam int GEAR_MIN_LSB     = 16;
  localparam int GEAR_CNT_LSB     = 24;
  // Lookup entry fields; LUT_LEN_LSB is the table length field of the index register
  localparam int LUT_MASK_LSB     = 16;
  localparam int LUT_MASK_W       = 13;
  localparam int LUT_RES_LSB      = 12;
  localparam int LUT_RISE_LSB     = 8;
  localparam int LUT_FALL_LSB     = 4;
  localparam int LUT_GEAR_LSB     = 0;
  localparam int LUT_LEN_LSB      = 8;
  // Codes and limits
  localparam logic [4:0] RESIDUAL_FULL = 5'h1f;
  localparam logic [4:0] SHAPING_MAX   = 5'h0f;
  localparam logic [3:0] GEARS_MAX     = 4'hf;
  // Reset values
  localparam logic [7:0]  RST_GUARD    = 8'h00;
  localparam logic [31:0] RST_LEVEL    = 32'h0000_0000;
  localparam logic [7:0]  RST_CLK      = 8'h07;
  localparam logic [31:0] RST_GEAR     = 32'h0100_ff00;
  // Timing
  localparam int CLK_NS           = 40;
  localparam int GUARD_UNIT_NS    = 1000;
  localparam int MEAS_UNIT_NS     = 10000;
  localparam int GUARD_UNIT_CYC   = (GUARD_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int MEAS_UNIT_CYC    = (MEAS_UNIT_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [0:0] {SCAN_IDLE, SCAN_RUN} scan_state_t;
endpackage

// [logic/rf_tx_guard_and_power_gear.sv]
// What this block does
// - Residual carrier is a 5-bit code; higher means less carrier, 31 removes it.
// - No transmission starts while the guard interval is still running.
// - Launch set and data ready before expiry starts transmission exactly at expiry.
// - Launch clear at expiry with grid sync enabled: later start aligns to bit grid.
// - Guard interval starts at end of every reception, good or bad.
// - Guard does not start on disturbance restart or with multi-frame receive enabled.
// - With field guard enabled, guard starts when own field switches on.
// - Guard time zero disables the guard interval entirely.
// - While shaping pattern is active, clock mode comes from its own field.
// - While shaping pattern is active, residual comes from its own field.
// - AGC is measured periodically at an interval set by a configured byte.
// - Each measurement compared to max and min; crossing one changes the gear.
// - Up to 15 gears, count set by software.
// - Entry holds mask, gear and falling, rising and residual deltas.
// - Entry bits: mask 28:16, residual 15:12, rising 11:8, falling 7:4, gear 3:0.
// - On gear switch or protocol load, matching deltas apply cumulatively up to gear; if no entry of that gear matches, values hold.
//
// Strobed register access and the address map were left to the implementer.
module rf_tx_guard_and_power_gear
  import rf_tx_gear_pkg::*;
#(
  parameter int LUT_DEPTH = 16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        rx_end,
  input  wire logic        rx_disturbance_restart,
  input  wire logic        tx_data_ready,
  input  wire logic        bit_grid_tick,
  input  wire logic        shaping_active,
  input  wire logic        agc_valid,
  input  wire logic [7:0]  agc_value,
  output logic             tx_start,
  output logic [2:0]       tx_clk_mode,
  output logic [4:0]       tx_residual,
  output logic             full_modulation,
  output logic [3:0]       falling_edge_shaping,
  output logic [3:0]       rising_edge_shaping,
  output logic [3:0]       gear,
  output logic             agc_measure_req
);
  import rf_tx_gear_pkg::*;

  // Saturating signed-magnitude delta
  function automatic logic [4:0] apply_delta(input logic [4:0] v, input logic [3:0] d, input logic [4:0] lim);
    logic [5:0] s;
    s = 6'h00;
    if (d[3]) begin
      s = (v > {2'b00, d[2:0]}) ? {1'b0, v} - {3'b000, d[2:0]} : 6'h00;
    end else begin
      s = {1'b0, v} + {3'b000, d[2:0]};
      if (s > {1'b0, lim}) begin
        s = {1'b0, lim};
      end
    end
    return s[4:0];
  endfunction

  logic [31:0] lut [LUT_DEPTH];
  logic [4:0]  ctrl_ff;
  logic [7:0]  guard_time_ff;
  logic [31:0] level_ff;
  logic [7:0]  clk_ff;
  logic [31:0] gear_cfg_ff;
  logic [12:0] proto_ff;
  logic [3:0]  lut_idx_ff;
  logic [4:0]  lut_len_ff;
  logic [15:0] guard_cnt_ff;
  logic        field_on_q_ff;
  logic        grid_armed_ff;
  logic        tx_start_ff;
  logic [15:0] meas_cnt_ff;
  logic [3:0]  gear_ff;
  logic        rescan_ff;
  scan_state_t scan_ff;
  logic [4:0]  scan_idx_ff;
  logic [4:0]  w_res_ff;
  logic [4:0]  w_fall_ff;
  logic [4:0]  w_rise_ff;
  logic        hit_ff;
  logic [4:0]  res_ff;
  logic [4:0]  fall_ff;
  logic [4:0]  rise_ff;
  logic [4:0]  out_res_ff;
  logic [2:0]  out_clk_ff;
  logic        full_mod_ff;
  logic        meas_req_ff;
  logic [31:0] rdata_ff;

  logic        wr_ctrl;
  logic        guard_start;
  logic        may_go;
  logic        go;
  logic [3:0]  gear_count;
  logic [31:0] entry;
  logic [3:0]  entry_gear;
  logic        entry_match;
  logic        scan_last;

  assign wr_ctrl     = reg_wr && (reg_addr == ADDR_CTRL);
  assign gear_count  = (gear_cfg_ff[GEAR_CNT_LSB +: 4] == 4'h0) ? 4'h1 :
                       (gear_cfg_ff[GEAR_CNT_LSB +: 4] > GEARS_MAX) ? GEARS_MAX : gear_cfg_ff[GEAR_CNT_LSB +: 4];
  assign guard_start = (guard_time_ff != RST_GUARD) &&
                       ((rx_end && !rx_disturbance_restart && !ctrl_ff[CTRL_MULTI_RX]) ||
                        (ctrl_ff[CTRL_FIELD_GUARD] && ctrl_ff[CTRL_FIELD_ON] && !field_on_q_ff));
  // A count of one means the interval ends on this edge
  assign may_go      = (guard_cnt_ff <= 16'h0001) && !guard_start;
  assign go          = ctrl_ff[CTRL_LAUNCH] && tx_data_ready && may_go && !tx_start_ff &&
                       (!grid_armed_ff || bit_grid_tick);

  // Register writes; launch set by software wins over its hardware clear
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff       <= 5'h00;
      guard_time_ff <= RST_GUARD;
      level_ff      <= RST_LEVEL;
      clk_ff        <= RST_CLK;
      gear_cfg_ff   <= RST_GEAR;
      proto_ff      <= 13'h0000;
      lut_idx_ff    <= 4'h0;
      lut_len_ff    <= 5'h00;
    end else begin
      if (go) begin
        ctrl_ff[CTRL_LAUNCH] <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_ff[4:1] <= reg_wdata[4:1];
        if (reg_wdata[CTRL_LAUNCH]) begin
          ctrl_ff[CTRL_LAUNCH] <= 1'b1;
        end
      end
      if (reg_wr && reg_addr == ADDR_GUARD) begin
        guard_time_ff <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == ADDR_LEVEL) begin
        level_ff <= reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_CLK) begin
        clk_ff <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == ADDR_GEAR) begin
        gear_cfg_ff <= reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_PROTO) begin
        proto_ff <= reg_wdata[LUT_MASK_W-1:0];
      end
      if (reg_wr && reg_addr == ADDR_LUT_IDX) begin
        lut_idx_ff <= reg_wdata[3:0];
        lut_len_ff <= (reg_wdata[LUT_LEN_LSB +: 5] > 5'(LUT_DEPTH)) ? 5'(LUT_DEPTH) : reg_wdata[LUT_LEN_LSB +: 5];
      end
      if (reg_wr && reg_addr == ADDR_LUT_DATA) begin
        lut_idx_ff <= lut_idx_ff + 4'h1;
      end
    end
  end

  // Table memory needs no reset
  always_ff @(posedge clk) begin
    if (reg_wr && reg_addr == ADDR_LUT_DATA) begin
      lut[lut_idx_ff] <= reg_wdata;
    end
  end

  // Guard interval and launch
  always_ff @(posedge clk) begin
    if (rst) begin
      guard_cnt_ff  <= 16'h0000;
      field_on_q_ff <= 1'b0;
      grid_armed_ff <= 1'b0;
      tx_start_ff   <= 1'b0;
    end else begin
      field_on_q_ff <= ctrl_ff[CTRL_FIELD_ON];
      tx_start_ff   <= go;
      if (guard_start) begin
        guard_cnt_ff <= 16'(32'(guard_time_ff) * GUARD_UNIT_CYC);
      end else if (guard_cnt_ff != 16'h0000) begin
        guard_cnt_ff <= guard_cnt_ff - 16'h0001;
      end
      if (go || guard_start) begin
        grid_armed_ff <= 1'b0;
      end else if (guard_cnt_ff == 16'h0001 && !ctrl_ff[CTRL_LAUNCH] && ctrl_ff[CTRL_GRID_SYNC]) begin
        grid_armed_ff <= 1'b1;
      end
    end
  end

  // Periodic AGC measurement and gear selection
  always_ff @(posedge clk) begin
    if (rst) begin
      meas_cnt_ff <= 16'h0000;
      meas_req_ff <= 1'b0;
      gear_ff     <= 4'h0;
    end else begin
      meas_req_ff <= 1'b0;
      if (meas_cnt_ff == 16'h0000) begin
        meas_cnt_ff <= 16'(32'(gear_cfg_ff[GEAR_IVL_LSB +: 8]) * MEAS_UNIT_CYC);
        meas_req_ff <= 1'b1;
      end else begin
        meas_cnt_ff <= meas_cnt_ff - 16'h0001;
      end
      if (gear_ff >= gear_count) begin
        gear_ff <= gear_count - 4'h1;
      end else if (agc_valid) begin
        if (agc_value > gear_cfg_ff[GEAR_MAX_LSB +: 8] && gear_ff < gear_count - 4'h1) begin
          gear_ff <= gear_ff + 4'h1;
        end else if (agc_value < gear_cfg_ff[GEAR_MIN_LSB +: 8] && gear_ff != 4'h0) begin
          gear_ff <= gear_ff - 4'h1;
        end
      end
    end
  end

  assign entry       = lut[scan_idx_ff[3:0]];
  assign entry_gear  = entry[LUT_GEAR_LSB +: 4];
  assign entry_match = (entry[LUT_MASK_LSB +: LUT_MASK_W] & proto_ff) != 13'h0000;
  // Sorted table lets the walk stop at the first higher gear
  assign scan_last   = (scan_idx_ff + 5'h01 >= lut_len_ff) || (entry_gear > gear_ff);

  // Lookup walk; any trigger during a walk restarts it
  always_ff @(posedge clk) begin
    if (rst) begin
      scan_ff     <= SCAN_IDLE;
      rescan_ff   <= 1'b1;
      scan_idx_ff <= 5'h00;
      w_res_ff    <= 5'h00;
      w_fall_ff   <= 5'h00;
      w_rise_ff   <= 5'h00;
      hit_ff      <= 1'b0;
      res_ff      <= RST_LEVEL[LVL_RES_LSB +: 5];
      fall_ff     <= {1'b0, RST_LEVEL[LVL_FALL_LSB +: 4]};
      rise_ff     <= {1'b0, RST_LEVEL[LVL_RISE_LSB +: 4]};
    end else begin
      rescan_ff <= (agc_valid && gear_ff < gear_count) || (reg_wr && (reg_addr == ADDR_PROTO ||
                   reg_addr == ADDR_LEVEL || reg_addr == ADDR_LUT_IDX));
      if (rescan_ff) begin
        scan_ff     <= SCAN_RUN;
        scan_idx_ff <= 5'h00;
        hit_ff      <= 1'b0;
        w_res_ff    <= level_ff[LVL_RES_LSB +: 5];
        w_fall_ff   <= {1'b0, level_ff[LVL_FALL_LSB +: 4]};
        w_rise_ff   <= {1'b0, level_ff[LVL_RISE_LSB +: 4]};
      end else begin
        case (scan_ff)
          SCAN_IDLE: begin
            scan_ff <= SCAN_IDLE;
          end
          SCAN_RUN: begin
            if (lut_len_ff == 5'h00) begin
              scan_ff <= SCAN_IDLE;
            end else begin
              if (entry_match && entry_gear <= gear_ff) begin
                w_res_ff  <= apply_delta(w_res_ff, entry[LUT_RES_LSB +: 4], RESIDUAL_FULL);
                w_fall_ff <= apply_delta(w_fall_ff, entry[LUT_FALL_LSB +: 4], SHAPING_MAX);
                w_rise_ff <= apply_delta(w_rise_ff, entry[LUT_RISE_LSB +: 4], SHAPING_MAX);
              end
              if (scan_last) begin
                scan_ff <= SCAN_IDLE;
                if (hit_ff || (entry_match && entry_gear == gear_ff)) begin
                  res_ff  <= (entry_match && entry_gear <= gear_ff) ?
                             apply_delta(w_res_ff, entry[LUT_RES_LSB +: 4], RESIDUAL_FULL) : w_res_ff;
                  fall_ff <= (entry_match && entry_gear <= gear_ff) ?
                             apply_delta(w_fall_ff, entry[LUT_FALL_LSB +: 4], SHAPING_MAX) : w_fall_ff;
                  rise_ff <= (entry_match && entry_gear <= gear_ff) ?
                             apply_delta(w_rise_ff, entry[LUT_RISE_LSB +: 4], SHAPING_MAX) : w_rise_ff;
                end
              end else begin
                scan_idx_ff <= scan_idx_ff + 5'h01;
                if (entry_match && entry_gear == gear_ff) begin
                  hit_ff <= 1'b1;
                end
              end
            end
          end
          default: begin
            scan_ff <= SCAN_IDLE;
          end
        endcase
      end
      if (reg_wr && reg_addr == ADDR_LEVEL) begin
        res_ff  <= reg_wdata[LVL_RES_LSB +: 5]; // New base shows at once; the walk then adds deltas
        fall_ff <= {1'b0, reg_wdata[LVL_FALL_LSB +: 4]};
        rise_ff <= {1'b0, reg_wdata[LVL_RISE_LSB +: 4]};
      end
    end
  end

  // Transmitter outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      out_res_ff  <= RST_LEVEL[LVL_RES_LSB +: 5];
      out_clk_ff  <= RST_CLK[CLK_MODE_LSB +: 3];
      full_mod_ff <= 1'b0;
    end else begin
      out_res_ff  <= shaping_active ? level_ff[LVL_RES_SHP_LSB +: 5] : res_ff;
      out_clk_ff  <= shaping_active ? clk_ff[CLK_SHP_LSB +: 3] : clk_ff[CLK_MODE_LSB +: 3];
      full_mod_ff <= (shaping_active ? level_ff[LVL_RES_SHP_LSB +: 5] : res_ff) == RESIDUAL_FULL;
    end
  end

  // Read port; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL:     rdata_ff <= {27'h0, ctrl_ff};
        ADDR_GUARD:    rdata_ff <= {24'h0, guard_time_ff};
        ADDR_LEVEL:    rdata_ff <= level_ff;
        ADDR_CLK:      rdata_ff <= {24'h0, clk_ff};
        ADDR_GEAR:     rdata_ff <= gear_cfg_ff;
        ADDR_PROTO:    rdata_ff <= {19'h0, proto_ff};
        ADDR_LUT_IDX:  rdata_ff <= {19'h0, lut_len_ff, 4'h0, lut_idx_ff};
        ADDR_STATUS:   rdata_ff <= {res_ff, 7'h00, rise_ff[3:0], fall_ff[3:0], gear_ff, 4'h0,
                                    scan_ff == SCAN_RUN, grid_armed_ff, guard_cnt_ff != 16'h0000, ctrl_ff[0]};
        default:       rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  assign reg_rdata            = rdata_ff;
  assign tx_start             = tx_start_ff;
  assign tx_clk_mode          = out_clk_ff;
  assign tx_residual          = out_res_ff;
  assign full_modulation      = full_mod_ff;
  assign falling_edge_shaping = fall_ff[3:0];
  assign rising_edge_shaping  = rise_ff[3:0];
  assign gear                 = gear_ff;
  assign agc_measure_req      = meas_req_ff;
endmodule

// [sim/rf_side_model.sv]
module rf_side_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       agc_measure_req,
  input  wire logic [7:0] agc_level,
  output logic            agc_valid,
  output logic [7:0]      agc_value,
  output logic            bit_grid_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] meas_ff;
  logic [2:0] grid_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      meas_ff <= 3'h0;
      grid_ff <= 3'h0;
    end else begin
      meas_ff <= {meas_ff[1:0], agc_measure_req};
      grid_ff <= grid_ff + 3'h1;
    end
  end
  // Converter answers three cycles after the request; idle bus carries junk, not the last reading
  assign agc_valid     = meas_ff[2];
  assign agc_value     = agc_valid ? agc_level : ~agc_level;
  assign bit_grid_tick = (grid_ff == 3'h7);
endmodule

// [sim/rf_tx_guard_and_power_gear_assertions.sv]
module rf_tx_gear_chk
  import rf_tx_gear_pkg::*;
#(
  parameter int LUT_DEPTH = 16
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        tx_data_ready,
  input wire logic        rx_end,
  input wire logic        rx_disturbance_restart,
  input wire logic        shaping_active,
  input wire logic        agc_valid,
  input wire logic        tx_start,
  input wire logic [2:0]  tx_clk_mode,
  input wire logic [4:0]  tx_residual,
  input wire logic        full_modulation,
  input wire logic [3:0]  gear,
  input wire logic        agc_measure_req
);
  // Shadow copies of the register fields the properties depend on
  logic [7:0] guard_ff;
  logic       multi_ff;
  logic [2:0] mode_ff;
  logic [2:0] mode_shp_ff;
  logic [4:0] res_shp_ff;
  logic [7:0] ivl_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      guard_ff    <= RST_GUARD;
      multi_ff    <= 1'b0;
      mode_ff     <= RST_CLK[2:0];
      mode_shp_ff <= RST_CLK[6:4];
      res_shp_ff  <= 5'h00;
      ivl_ff      <= RST_GEAR[7:0];
    end else if (reg_wr) begin
      if (reg_addr == ADDR_GUARD) guard_ff <= reg_wdata[7:0];
      if (reg_addr == ADDR_CTRL) multi_ff <= reg_wdata[CTRL_MULTI_RX];
      if (reg_addr == ADDR_CLK) mode_ff <= reg_wdata[2:0];
      if (reg_addr == ADDR_CLK) mode_shp_ff <= reg_wdata[6:4];
      if (reg_addr == ADDR_LEVEL) res_shp_ff <= reg_wdata[12:8];
      if (reg_addr == ADDR_GEAR) ivl_ff <= reg_wdata[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_full; full_modulation == (tx_residual == 5'h1f); endproperty
  a_full: assert property (p_full) else $error("full modulation flag disagrees with residual");
  property p_guard; rx_end && !rx_disturbance_restart && !multi_ff && guard_ff != 8'h00 |=> !tx_start [*8]; endproperty
  a_guard: assert property (p_guard) else $error("start while guard interval runs");
  property p_ready; tx_start |-> $past(tx_data_ready); endproperty
  a_ready: assert property (p_ready) else $error("start without payload ready");
  property p_mode_shp; $past(shaping_active) |-> tx_clk_mode == $past(mode_shp_ff); endproperty
  a_mode_shp: assert property (p_mode_shp) else $error("wrong clock mode while shaping");
  property p_mode_norm; !$past(shaping_active) |-> tx_clk_mode == $past(mode_ff); endproperty
  a_mode_norm: assert property (p_mode_norm) else $error("wrong normal clock mode");
  property p_res_shp; $past(shaping_active) |-> tx_residual == $past(res_shp_ff); endproperty
  a_res_shp: assert property (p_res_shp) else $error("wrong residual while shaping");
  property p_meas; agc_measure_req && ivl_ff != 8'h00 && $stable(ivl_ff) |=> !agc_measure_req [*8]; endproperty
  a_meas: assert property (p_meas) else $error("measurement requests too close");
  property p_step; $changed(gear) |-> gear == $past(gear) + 4'h1 || gear == $past(gear) - 4'h1; endproperty
  a_step: assert property (p_step) else $error("gear moved by more than one");
  property p_cause; $changed(gear) |-> $past(agc_valid) || $past(agc_valid, 2); endproperty
  a_cause: assert property (p_cause) else $error("gear changed without a measurement");
  property p_max; gear != GEARS_MAX; endproperty
  a_max: assert property (p_max) else $error("gear beyond the fifteen available");
  c_start: cover property (tx_start);
  c_gear: cover property ($changed(gear));
  c_shape: cover property (shaping_active && full_modulation);
endmodule

bind rf_tx_guard_and_power_gear rf_tx_gear_chk #(.LUT_DEPTH(LUT_DEPTH)) chk_u (.clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .tx_data_ready, .rx_end, .rx_disturbance_restart, .shaping_active, .agc_valid, .tx_start, .tx_clk_mode,
  .tx_residual, .full_modulation, .gear, .agc_measure_req);

// [sim/rf_tx_guard_and_power_gear_tb.sv]
module rf_tx_guard_and_power_gear_tb
  import rf_tx_gear_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        rx_end = 1'b0;
  logic        rx_disturbance_restart = 1'b0;
  logic        tx_data_ready = 1'b0;
  logic        bit_grid_tick;
  logic        shaping_active = 1'b0;
  logic        agc_valid;
  logic [7:0]  agc_value;
  logic [7:0]  agc_level = 8'h40;
  logic        tx_start;
  logic [2:0]  tx_clk_mode;
  logic [4:0]  tx_residual;
  logic        full_modulation;
  logic [3:0]  falling_edge_shaping;
  logic [3:0]  rising_edge_shaping;
  logic [3:0]  gear;
  logic        agc_measure_req;
  int          errors = 0;
  int          n_checks = 0;
  logic [31:0] d;
  int          n;
  logic        tk;

  always #20 clk = ~clk;

  rf_tx_guard_and_power_gear #(.LUT_DEPTH(16)) dut_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rx_end, .rx_disturbance_restart, .tx_data_ready, .bit_grid_tick, .shaping_active, .agc_valid, .agc_value,
    .tx_start, .tx_clk_mode, .tx_residual, .full_modulation, .falling_edge_shaping, .rising_edge_shaping, .gear,
    .agc_measure_req);
  rf_side_model model_u (.clk, .rst, .agc_measure_req, .agc_level, .agc_valid, .agc_value, .bit_grid_tick);

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic pulse_rx(input logic restart);
    @(posedge clk);
    rx_end                 <= 1'b1;
    rx_disturbance_restart <= restart;
    tx_data_ready          <= 1'b1;
    @(posedge clk);
    rx_end                 <= 1'b0;
    rx_disturbance_restart <= 1'b0;
  endtask

  // Counts falling edges until a start shows; tk keeps the grid tick of the cycle before it
  task automatic wait_start(input int lim);
    n  = 0;
    tk = 1'b0;
    while (tx_start !== 1'b1) begin
      tk = bit_grid_tick;
      @(negedge clk);
      n++;
      if (n > lim) begin
        errors++;
        $display("CHECK FAILED tx_start expected pulse seen none");
        results();
      end
    end
  endtask

  task automatic wait_gear(input logic [3:0] g);
    n = 0;
    while (gear !== g) begin
      @(negedge clk);
      n++;
      if (n > 2000) begin
        errors++;
        $display("CHECK FAILED gear expected %h seen %h", g, gear);
        results();
      end
    end
  endtask

  task automatic t_reset();
    rd(ADDR_CLK);
    chk("clock cfg reset", d, 32'h0000_0007);
    rd(ADDR_GEAR);
    chk("gear cfg reset", d, 32'h0100_ff00);
    rd(8'h24);
    chk("unmapped read", d, 32'h0);
    chk("clock mode reset", 32'(tx_clk_mode), 32'h7);
    $display("reset test done");
  endtask

  task automatic t_guard();
    wr(ADDR_GUARD, 32'h2);
    wr(ADDR_CTRL, 32'h1);
    pulse_rx(1'b0);
    wait_start(80);
    chk("guard delay", 32'(n >= 51 && n <= 52), 32'h1);
    rd(ADDR_CTRL);
    chk("launch cleared", 32'(d[CTRL_LAUNCH]), 32'h0);
    n = 0;
    repeat (60) begin
      @(negedge clk);
      if (tx_start !== 1'b0) n++;
    end
    chk("unrequested starts", 32'(n), 32'h0);
    wr(ADDR_GUARD, 32'h0);
    pulse_rx(1'b0);
    wr(ADDR_CTRL, 32'h1);
    wait_start(10);
    chk("start with guard off", 32'(n <= 3), 32'h1);
    $display("guard test done");
  endtask

  task automatic t_rx_cond();
    wr(ADDR_GUARD, 32'h2);
    wr(ADDR_CTRL, 32'h8);
    pulse_rx(1'b0);
    rd(ADDR_STATUS);
    chk("guard on multi rx", 32'(d[1]), 32'h0);
    wr(ADDR_CTRL, 32'h0);
    pulse_rx(1'b1);
    rd(ADDR_STATUS);
    chk("guard on restart", 32'(d[1]), 32'h0);
    pulse_rx(1'b0);
    rd(ADDR_STATUS);
    chk("guard on rx end", 32'(d[1]), 32'h1);
    repeat (60) @(negedge clk);
    wr(ADDR_CTRL, 32'h4);
    wr(ADDR_CTRL, 32'h14);
    rd(ADDR_STATUS);
    chk("guard on field on", 32'(d[1]), 32'h1);
    repeat (60) @(negedge clk);
    $display("reception test done");
  endtask

  task automatic t_grid();
    wr(ADDR_CTRL, 32'h2);
    pulse_rx(1'b0);
    repeat (60) @(negedge clk);
    rd(ADDR_STATUS);
    chk("grid armed", 32'(d[2]), 32'h1);
    wr(ADDR_CTRL, 32'h3);
    wait_start(20);
    chk("start on grid tick", 32'(tk), 32'h1);
    $display("grid test done");
  endtask

  task automatic t_shape();
    wr(ADDR_CLK, 32'h25);
    wr(ADDR_LEVEL, 32'h0000_1f03);
    @(posedge clk);
    shaping_active <= 1'b1;
    repeat (3) @(negedge clk);
    chk("shaping clock mode", 32'(tx_clk_mode), 32'h2);
    chk("shaping residual", 32'(tx_residual), 32'h1f);
    chk("full modulation", 32'(full_modulation), 32'h1);
    @(posedge clk);
    shaping_active <= 1'b0;
    repeat (3) @(negedge clk);
    chk("normal clock mode", 32'(tx_clk_mode), 32'h5);
    chk("normal residual", 32'(tx_residual), 32'h3);
    chk("partial modulation", 32'(full_modulation), 32'h0);
    $display("shaping test done");
  endtask

  task automatic t_gear();
    wr(ADDR_LUT_IDX, 32'h0000_0200);
    wr(ADDR_LUT_DATA, 32'h0001_2001);
    wr(ADDR_LUT_DATA, 32'h0001_1012);
    wr(ADDR_PROTO, 32'h1);
    wr(ADDR_LEVEL, 32'h0003_0004);
    wr(ADDR_GEAR, 32'h0310_8001);
    @(posedge clk);
    agc_level <= 8'hf0;
    wait_gear(4'h2);
    repeat (600) @(negedge clk);
    chk("gear held at top", 32'(gear), 32'h2);
    chk("residual gear 2", 32'(tx_residual), 32'h7);
    chk("falling gear 2", 32'(falling_edge_shaping), 32'h4);
    chk("rising gear 2", 32'(rising_edge_shaping), 32'h0);
    @(posedge clk);
    agc_level <= 8'h05;
    wait_gear(4'h1);
    @(posedge clk);
    agc_level <= 8'h40;
    repeat (10) @(negedge clk);
    chk("residual gear 1", 32'(tx_residual), 32'h6);
    chk("falling gear 1", 32'(falling_edge_shaping), 32'h3);
    wr(ADDR_PROTO, 32'h2);
    repeat (10) @(negedge clk);
    chk("residual no match", 32'(tx_residual), 32'h6);
    chk("falling no match", 32'(falling_edge_shaping), 32'h3);
    rd(ADDR_STATUS);
    chk("status gear", 32'(d[11:8]), 32'h1);
    $display("gear test done");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_guard();
    t_rx_cond();
    t_grid();
    t_shape();
    t_gear();
    results();
  end
endmodule
